// >>> include/ppcsr_map.svh
// register selects, field positions, reset values, codes and timing for the port registers
`ifndef PPCSR_MAP_SVH
`define PPCSR_MAP_SVH
`define PPCSR_SEL_FCTL 4'h2
`define PPCSR_SEL_ECTL 4'h3
`define PPCSR_SEL_STAT 4'h4
`define PPCSR_FCTL_RST 8'h00
`define PPCSR_ECTL_RST 8'h00
`define PPCSR_STAT_RST 8'h00
`define PPCSR_FCTL_MASK 8'h3f
`define PPCSR_ECTL_MASK 8'h1c
`define PPCSR_FCTL_DCOVR_BIT 4
`define PPCSR_FCTL_DFOVR_BIT 5
`define PPCSR_ECTL_DIS_BIT 4
`define PPCSR_ECTL_START_BIT 3
`define PPCSR_ECTL_ABORT_BIT 2
`define PPCSR_STAT_DFAIL_BIT 7
`define PPCSR_STAT_DONE_BIT 6
`define PPCSR_STAT_CLASS_LSB 3
`define PPCSR_STAT_FAULT_LSB 0
`define PPCSR_FN_OFF 4'h0
`define PPCSR_FN_DISC1 4'h1
`define PPCSR_FN_DISC2 4'h2
`define PPCSR_FN_VSAMP 4'h3
`define PPCSR_FN_LEGACY 4'h4
`define PPCSR_FN_CLASSIFY 4'h5
`define PPCSR_FN_RAMPUP 4'h6
`define PPCSR_FN_CSAMP 4'h7
`define PPCSR_FN_RAMPDN 4'h8
`define PPCSR_FN_ACLO 4'h9
`define PPCSR_FN_ACHI 4'ha
`define PPCSR_FN_ISAMP 4'hb
`define PPCSR_FN_TSAMP 4'hc
`define PPCSR_FLT_NONE 3'h0
`define PPCSR_FLT_SUPPLY 3'h1
`define PPCSR_FLT_HEAT 3'h2
`define PPCSR_FLT_OVL 3'h3
`define PPCSR_FLT_DISC 3'h4
`define PPCSR_CLASS_MAX 3'h4
`define PPCSR_OVL_MS 50
`define PPCSR_CLK_MHZ 250
`endif

// >>> include/ppcsr_pkg.sv
// types shared by the port register bank modules
package ppcsr_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_BUSY, ST_HOLD} ppcsr_state_e;
  typedef logic [3:0] ppcsr_func_t;
  typedef logic [2:0] ppcsr_code_t;
endpackage

// >>> include/ppcsr_port_if.sv
// per-port link between the register bank and its function sequencer
interface ppcsr_port_if;
  ppcsr_pkg::ppcsr_func_t func;
  logic start;
  logic disc_ovr;
  logic dc_ovr;
  logic port_dis;
  logic fe_done;
  logic fe_in_window;
  ppcsr_pkg::ppcsr_code_t fe_class;
  logic fe_supply;
  logic fe_heat;
  logic ovl_expired;
  logic fe_dc_disc;
  logic power_en;
  logic done;
  logic disc_fail;
  ppcsr_pkg::ppcsr_code_t cls;
  ppcsr_pkg::ppcsr_code_t fault;
  modport ctl (
    output func, start, disc_ovr, dc_ovr, port_dis, fe_done, fe_in_window, fe_class,
    output fe_supply, fe_heat, ovl_expired, fe_dc_disc,
    input power_en, done, disc_fail, cls, fault
  );
  modport fsm (
    input func, start, disc_ovr, dc_ovr, port_dis, fe_done, fe_in_window, fe_class,
    input fe_supply, fe_heat, ovl_expired, fe_dc_disc,
    output power_en, done, disc_fail, cls, fault
  );
endinterface

// >>> src/ppcsr_ovl_timer.sv
// overload duration timer: flags an overcurrent that outlasts the limit
module ppcsr_ovl_timer #(
  parameter logic [23:0] CYCLES = 24'hbebc20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // overcurrent level and timeout flag
  input wire logic run,
  output logic expired
);
  logic [23:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (!run) begin
      // any break in the overcurrent restarts the window
      cnt_d = 24'h000000;
      exp_d = 1'b0;
    end else if (cnt_q == CYCLES - 24'h000001) begin
      exp_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h000000;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule

// >>> src/ppcsr_port_fsm.sv
// per-port function sequencer: runs the selected function and keeps port status
`include "ppcsr_map.svh"
module ppcsr_port_fsm (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bank side
  ppcsr_port_if.fsm pif
);
  ppcsr_pkg::ppcsr_state_e state_q, state_d;
  logic power_q, power_d;
  logic done_q, done_d;
  logic dfail_q, dfail_d;
  ppcsr_pkg::ppcsr_code_t cls_q, cls_d;
  ppcsr_pkg::ppcsr_code_t fault_q, fault_d;
  logic finish;

  always_comb begin
    state_d = state_q;
    power_d = power_q;
    done_d = done_q;
    dfail_d = dfail_q;
    cls_d = cls_q;
    fault_d = fault_q;
    finish = (state_q == ppcsr_pkg::ST_BUSY) && pif.fe_done;
    if (finish) begin
      state_d = ppcsr_pkg::ST_HOLD;
      case (pif.func)
        `PPCSR_FN_DISC1, `PPCSR_FN_DISC2: begin
          dfail_d = !pif.disc_ovr && !pif.fe_in_window;
        end
        `PPCSR_FN_CLASSIFY: begin
          cls_d = (pif.fe_class > `PPCSR_CLASS_MAX) ? `PPCSR_CLASS_MAX : pif.fe_class;
        end
        default: begin
        end
      endcase
    end
    if (pif.start) begin
      done_d = 1'b0;
      case (pif.func)
        `PPCSR_FN_OFF: begin
          state_d = ppcsr_pkg::ST_OFF;
          power_d = 1'b0;
          dfail_d = 1'b0;
          cls_d = 3'h0;
          fault_d = `PPCSR_FLT_NONE;
          done_d = 1'b1;
        end
        `PPCSR_FN_DISC1, `PPCSR_FN_DISC2: begin
          state_d = ppcsr_pkg::ST_BUSY;
          dfail_d = 1'b0;
        end
        `PPCSR_FN_VSAMP, `PPCSR_FN_ISAMP, `PPCSR_FN_TSAMP: begin
          state_d = ppcsr_pkg::ST_BUSY;
        end
        `PPCSR_FN_LEGACY, `PPCSR_FN_CLASSIFY: begin
          state_d = ppcsr_pkg::ST_BUSY;
        end
        `PPCSR_FN_RAMPUP: begin
          state_d = ppcsr_pkg::ST_BUSY;
          power_d = 1'b1;
          fault_d = `PPCSR_FLT_NONE;
        end
        `PPCSR_FN_RAMPDN: begin
          state_d = ppcsr_pkg::ST_BUSY;
          power_d = 1'b0;
        end
        `PPCSR_FN_ACLO, `PPCSR_FN_ACHI: begin
          state_d = ppcsr_pkg::ST_BUSY;
        end
        `PPCSR_FN_CSAMP: begin
          // continuous sampling never completes
          state_d = ppcsr_pkg::ST_HOLD;
        end
        default: begin
          // spare codes do nothing at all
          done_d = done_q;
        end
      endcase
    end
    // completion of the old function wins over the clear of a new write
    if (finish) begin
      done_d = 1'b1;
    end
    if (power_q) begin
      if (pif.fe_heat) begin
        fault_d = `PPCSR_FLT_HEAT;
      end else if (pif.fe_supply) begin
        fault_d = `PPCSR_FLT_SUPPLY;
      end else if (pif.ovl_expired) begin
        fault_d = `PPCSR_FLT_OVL;
      end else if (pif.fe_dc_disc && !pif.dc_ovr) begin
        fault_d = `PPCSR_FLT_DISC;
      end
      if (pif.fe_heat || pif.fe_supply || pif.ovl_expired || (pif.fe_dc_disc && !pif.dc_ovr)) begin
        power_d = 1'b0;
        state_d = ppcsr_pkg::ST_OFF;
      end
    end
    if (pif.port_dis) begin
      power_d = 1'b0;
      state_d = ppcsr_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ppcsr_pkg::ST_OFF;
      power_q <= 1'b0;
      done_q <= 1'b0;
      dfail_q <= 1'b0;
      cls_q <= 3'h0;
      fault_q <= `PPCSR_FLT_NONE;
    end else begin
      state_q <= state_d;
      power_q <= power_d;
      done_q <= done_d;
      dfail_q <= dfail_d;
      cls_q <= cls_d;
      fault_q <= fault_d;
    end
  end

  assign pif.power_en = power_q;
  assign pif.done = done_q;
  assign pif.disc_fail = dfail_q;
  assign pif.cls = cls_q;
  assign pif.fault = fault_q;
endmodule

// >>> src/ppcsr_regs.sv
// per-port control and status registers of a four-port power sourcing manager
`include "ppcsr_map.svh"
module ppcsr_regs #(
  parameter int unsigned OVL_CYCLES = `PPCSR_OVL_MS * 1000 * `PPCSR_CLK_MHZ
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register access
  input wire logic [3:0] REG_SEL,
  input wire logic [1:0] PORT_SEL,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  // port front end observations
  input wire logic [3:0] FE_STEP_DONE,
  input wire logic [3:0] FE_SIG_IN_WINDOW,
  input wire logic [11:0] FE_CLASS,
  input wire logic [3:0] SUPPLY_WINDOW_FAULT,
  input wire logic OVERHEAT_SHUTDOWN,
  input wire logic [3:0] FE_OVERCURRENT,
  input wire logic [3:0] FE_DC_DISCONNECT,
  input wire logic [3:0] ADC_DONE,
  // port front end controls
  output logic [3:0] PORT_POWER_EN,
  output logic [15:0] PORT_FUNC,
  output logic [3:0] SIG_WINDOW_EN,
  output logic [3:0] DC_DISC_EN,
  output logic [3:0] ADC_START,
  output logic [3:0] ADC_ABORT
);
  localparam logic [23:0] OVL_CNT = 24'(OVL_CYCLES);

  logic [7:0] fctl_q [4];
  logic [7:0] fctl_d [4];
  logic [7:0] ectl_q [4];
  logic [7:0] ectl_d [4];
  logic [3:0] fstart_q, fstart_d;
  logic [3:0] astart_q, astart_d;
  logic [3:0] wdis_q, wdis_d;
  logic [3:0] dcen_q, dcen_d;
  logic [7:0] rd_q, rd_d;
  logic [7:0] stat_w [4];
  logic [3:0] ovl_exp;

  ppcsr_port_if pif [4] ();

  // one decode shared by the write and the read paths
  function automatic logic sel_is(input logic [3:0] sel, input logic [3:0] code);
    sel_is = (sel == code);
  endfunction

  always_comb begin
    fstart_d = 4'h0;
    astart_d = 4'h0;
    for (int i = 0; i < 4; i++) begin
      fctl_d[i] = fctl_q[i];
      ectl_d[i] = ectl_q[i];
      // conversion finished or aborted: start bit drops by itself
      if (ADC_DONE[i] || ectl_q[i][`PPCSR_ECTL_ABORT_BIT]) begin
        ectl_d[i][`PPCSR_ECTL_START_BIT] = 1'b0;
      end
      if (WR_STB && (PORT_SEL == 2'(i))) begin
        if (sel_is(REG_SEL, `PPCSR_SEL_FCTL)) begin
          fctl_d[i] = WR_DATA & `PPCSR_FCTL_MASK;
          fstart_d[i] = 1'b1;
        end
        if (sel_is(REG_SEL, `PPCSR_SEL_ECTL)) begin
          // a fresh write wins over the self clear in the same cycle
          ectl_d[i] = WR_DATA & `PPCSR_ECTL_MASK;
          astart_d[i] = WR_DATA[`PPCSR_ECTL_START_BIT];
        end
      end
    end
    for (int i = 0; i < 4; i++) begin
      wdis_d[i] = ~fctl_d[i][`PPCSR_FCTL_DFOVR_BIT];
      dcen_d[i] = ~fctl_d[i][`PPCSR_FCTL_DCOVR_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        fctl_q[i] <= `PPCSR_FCTL_RST;
        ectl_q[i] <= `PPCSR_ECTL_RST;
      end
      fstart_q <= 4'h0;
      astart_q <= 4'h0;
      wdis_q <= 4'hf;
      dcen_q <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        fctl_q[i] <= fctl_d[i];
        ectl_q[i] <= ectl_d[i];
      end
      fstart_q <= fstart_d;
      astart_q <= astart_d;
      wdis_q <= wdis_d;
      dcen_q <= dcen_d;
    end
  end

  // read data is registered; status and control writes of other types ignored
  always_comb begin
    rd_d = rd_q;
    if (RD_STB) begin
      if (sel_is(REG_SEL, `PPCSR_SEL_FCTL)) begin
        rd_d = fctl_q[PORT_SEL];
      end else if (sel_is(REG_SEL, `PPCSR_SEL_ECTL)) begin
        rd_d = ectl_q[PORT_SEL];
      end else if (sel_is(REG_SEL, `PPCSR_SEL_STAT)) begin
        rd_d = stat_w[PORT_SEL];
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_port
    assign pif[g].func = fctl_q[g][3:0];
    assign pif[g].start = fstart_q[g];
    assign pif[g].disc_ovr = fctl_q[g][`PPCSR_FCTL_DFOVR_BIT];
    assign pif[g].dc_ovr = fctl_q[g][`PPCSR_FCTL_DCOVR_BIT];
    assign pif[g].port_dis = ectl_q[g][`PPCSR_ECTL_DIS_BIT];
    assign pif[g].fe_done = FE_STEP_DONE[g];
    assign pif[g].fe_in_window = FE_SIG_IN_WINDOW[g];
    assign pif[g].fe_class = FE_CLASS[3*g +: 3];
    assign pif[g].fe_supply = SUPPLY_WINDOW_FAULT[g];
    assign pif[g].fe_heat = OVERHEAT_SHUTDOWN;
    assign pif[g].ovl_expired = ovl_exp[g];
    assign pif[g].fe_dc_disc = FE_DC_DISCONNECT[g];

    // timer only runs while the port is delivering power
    ppcsr_ovl_timer #(
      .CYCLES(OVL_CNT)
    ) u_ovl (
      .clk(MCLK),
      .rst_n(RST_N),
      .run(FE_OVERCURRENT[g] && pif[g].power_en),
      .expired(ovl_exp[g])
    );

    ppcsr_port_fsm u_fsm (
      .clk(MCLK),
      .rst_n(RST_N),
      .pif(pif[g])
    );

    assign stat_w[g] = {pif[g].disc_fail, pif[g].done, pif[g].cls, pif[g].fault};

    assign PORT_POWER_EN[g] = pif[g].power_en;
    assign PORT_FUNC[4*g +: 4] = fctl_q[g][3:0];
    assign ADC_ABORT[g] = ectl_q[g][`PPCSR_ECTL_ABORT_BIT];
  end

  assign RD_DATA = rd_q;
  assign SIG_WINDOW_EN = wdis_q;
  assign DC_DISC_EN = dcen_q;
  assign ADC_START = astart_q;
endmodule

// >>> verif/ppcsr_regs_chk.sv
// pin-level assertions for the port register bank
module ppcsr_regs_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register access
  input wire logic [3:0] REG_SEL,
  input wire logic [1:0] PORT_SEL,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  // front end controls
  input wire logic [3:0] PORT_POWER_EN,
  input wire logic [15:0] PORT_FUNC,
  input wire logic [3:0] SIG_WINDOW_EN,
  input wire logic [3:0] ADC_START,
  input wire logic [3:0] ADC_ABORT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_fwr;
    WR_STB && REG_SEL == 4'h2;
  endsequence
  sequence s_ewr;
    WR_STB && REG_SEL == 4'h3;
  endsequence
  a_func_copy:
  assert property (s_fwr |=> PORT_FUNC[4*$past(PORT_SEL)+:4] == $past(WR_DATA[3:0]))
    else $error("function code not passed on");
  a_window_en:
  assert property (s_fwr |=> SIG_WINDOW_EN[$past(PORT_SEL)] != $past(WR_DATA[5]))
    else $error("window enable wrong");
  a_abort_level:
  assert property (s_ewr |=> ADC_ABORT[$past(PORT_SEL)] == $past(WR_DATA[2]))
    else $error("abort level wrong");
  a_start_pulse:
  assert property (s_ewr ##0 WR_DATA[3] |=> ADC_START[$past(PORT_SEL)])
    else $error("conversion start missing");
  a_disable_off:
  assert property (s_ewr ##0 WR_DATA[4] |=> ##1 !PORT_POWER_EN[$past(PORT_SEL, 2)])
    else $error("disabled port still powered");
  a_code_off:
  assert property (s_fwr ##0 WR_DATA[3:0] == 4'h0 |=> ##1 !PORT_POWER_EN[$past(PORT_SEL, 2)])
    else $error("port powered after off code");
  a_unmapped_zero:
  assert property (RD_STB && !(REG_SEL inside {4'h2, 4'h3, 4'h4}) |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  a_class_max:
  assert property (RD_STB && REG_SEL == 4'h4 |=> RD_DATA[5:3] <= 3'h4)
    else $error("class above four");
endmodule
bind ppcsr_regs ppcsr_regs_chk u_chk (.*);

// >>> verif/ppcsr_fe_model.sv
// analog front end model: answers steps and conversions after a delay
module ppcsr_fe_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // answer delay in cycles, 1 is prompt
  input wire logic [7:0] dly,
  // controls from the bank
  input wire logic [15:0] func,
  input wire logic [3:0] start,
  // answers
  output logic [3:0] step_done,
  output logic [3:0] adc_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sc_q [4];
  logic [7:0] ac_q [4];
  logic [15:0] func_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= 16'h0000;
      step_done <= 4'h0;
      adc_done <= 4'h0;
      sc_q <= '{default: 8'h00};
      ac_q <= '{default: 8'h00};
    end else begin
      func_q <= func;
      for (int p = 0; p < 4; p++) begin
        step_done[p] <= sc_q[p] == 8'h01;
        adc_done[p] <= ac_q[p] == 8'h01;
        // a new code restarts the step; rewriting the same code does not
        sc_q[p] <= (func[4*p+:4] != func_q[4*p+:4]) ? dly : sc_q[p] - (sc_q[p] != 8'h00);
        ac_q[p] <= start[p] ? dly : ac_q[p] - (ac_q[p] != 8'h00);
      end
    end
  end
endmodule

// >>> verif/ppcsr_regs_tb.sv
// self-checking bench for the port register bank
module ppcsr_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, heat = 0;
  logic [3:0] sel = 0, win = 0, supf = 0, ovc = 0, dcd = 0, stepd, adcd;
  logic [3:0] pwr, swin, dcen, ast, aab;
  logic [1:0] port = 0;
  logic [7:0] wdata = 0, rdata, v, dly = 8'h01;
  logic [7:0] dtab [4] = '{8'h01, 8'h02, 8'h21, 8'h22};
  logic [11:0] cls = 0;
  logic [15:0] func;
  int fails = 0, compares = 0;
  ppcsr_regs #(.OVL_CYCLES(20)) dut (.MCLK(mclk), .RST_N(rst_n), .REG_SEL(sel),
    .PORT_SEL(port), .WR_STB(wr_stb), .WR_DATA(wdata), .RD_STB(rd_stb), .RD_DATA(rdata),
    .FE_STEP_DONE(stepd), .FE_SIG_IN_WINDOW(win), .FE_CLASS(cls),
    .SUPPLY_WINDOW_FAULT(supf), .OVERHEAT_SHUTDOWN(heat), .FE_OVERCURRENT(ovc),
    .FE_DC_DISCONNECT(dcd), .ADC_DONE(adcd), .PORT_POWER_EN(pwr), .PORT_FUNC(func),
    .SIG_WINDOW_EN(swin), .DC_DISC_EN(dcen), .ADC_START(ast), .ADC_ABORT(aab));
  ppcsr_fe_model fe (.clk(mclk), .rst_n(rst_n), .dly(dly), .func(func), .start(ast),
    .step_done(stepd), .adc_done(adcd));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    fails++;
    report_and_stop();
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle; read data is registered by the same edge
  task automatic bus(input logic [3:0] s, input logic [1:0] p, input logic [7:0] d,
                     input logic w);
    @(posedge mclk) #1;
    sel = s;
    port = p;
    wdata = d;
    wr_stb = w;
    rd_stb = !w;
    @(posedge mclk) #1;
    wr_stb = 0;
    rd_stb = 0;
  endtask
  task automatic wr(input logic [3:0] s, input logic [1:0] p, input logic [7:0] d);
    bus(s, p, d, 1'b1);
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] p, input logic [7:0] m,
                    input logic [7:0] e);
    bus(s, p, 8'h00, 1'b0);
    chk8(rdata & m, e);
  endtask
  task automatic wait_done(input logic [1:0] p);
    for (int n = 0; n < 60; n++) begin
      bus(4'h4, p, 8'h00, 1'b0);
      if (rdata[6] === 1'b1) begin
        return;
      end
    end
    timeout();
  endtask
  task automatic wait_off(input logic [1:0] p);
    for (int n = 0; n < 100 && pwr[p] !== 1'b0; n++) begin
      @(posedge mclk) #1;
    end
    if (pwr[p] !== 1'b0) begin
      timeout();
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 16; s++) begin
        rd(s[3:0], p[1:0], 8'hff, 8'h00);
      end
    end
    for (int p = 0; p < 4; p++) begin
      wr(4'h2, p[1:0], 8'hed + p[7:0]);
    end
    for (int p = 0; p < 4; p++) begin
      v = 8'hed + p[7:0];
      rd(4'h2, p[1:0], 8'hff, v & 8'h3f);
      chk8({4'h0, func[4*p+:4]}, v & 8'h0f);
      chk8({6'h00, swin[p], dcen[p]}, {7'h00, !v[4]});
    end
    wr(4'h3, 2'h0, 8'he7);
    rd(4'h3, 2'h0, 8'hff, 8'h04);
    chk8({7'h00, aab[0]}, 8'h01);
    wr(4'h3, 2'h0, 8'hf3);
    rd(4'h3, 2'h0, 8'hff, 8'h10);
    wr(4'h3, 2'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      win[2] = (i == 1);
      wr(4'h2, 2'h2, dtab[i]);
      wait_done(2'h2);
      rd(4'h4, 2'h2, 8'hff, (i == 0) ? 8'hc0 : 8'h40);
    end
    for (int k = 0; k < 2; k++) begin
      cls[11:9] = k ? 3'h7 : 3'h3;
      wr(4'h2, 2'h3, 8'h00);
      wr(4'h2, 2'h3, 8'h05);
      wait_done(2'h3);
      rd(4'h4, 2'h3, 8'hff, k ? 8'h60 : 8'h58);
    end
    // slow answers from here on
    dly = 8'h0c;
    for (int c = 3; c < 13; c++) begin
      if (c != 7) begin
        wr(4'h2, 2'h1, c[7:0]);
        wait_done(2'h1);
        if (c == 6 || c == 8) begin
          chk8({7'h00, pwr[1]}, {7'h00, c == 6});
        end
      end
    end
    wr(4'h2, 2'h1, 8'h07);
    repeat (30) @(posedge mclk);
    rd(4'h4, 2'h1, 8'h40, 8'h00);
    for (int k = 1; k < 5; k++) begin
      wr(4'h2, 2'h1, 8'h00);
      rd(4'h4, 2'h1, 8'hff, 8'h40);
      wr(4'h2, 2'h1, 8'h06);
      wait_done(2'h1);
      chk8({7'h00, pwr[1]}, 8'h01);
      supf[1] = (k == 1);
      heat = (k == 2);
      ovc[1] = (k == 3);
      dcd[1] = (k == 4);
      wait_off(2'h1);
      rd(4'h4, 2'h1, 8'h07, k[7:0]);
      {supf, heat, ovc, dcd} = 13'h0000;
    end
    wr(4'h2, 2'h1, 8'h00);
    wr(4'h2, 2'h1, 8'h16);
    wait_done(2'h1);
    dcd[1] = 1;
    repeat (30) @(posedge mclk);
    chk8({7'h00, pwr[1]}, 8'h01);
    rd(4'h4, 2'h1, 8'h07, 8'h00);
    dcd[1] = 0;
    wr(4'h3, 2'h1, 8'h10);
    @(posedge mclk) #1;
    chk8({7'h00, pwr[1]}, 8'h00);
    wr(4'h3, 2'h1, 8'h00);
    wr(4'h3, 2'h0, 8'h08);
    rd(4'h3, 2'h0, 8'hff, 8'h08);
    repeat (20) @(posedge mclk);
    rd(4'h3, 2'h0, 8'hff, 8'h00);
    wr(4'h3, 2'h0, 8'h08);
    wr(4'h3, 2'h0, 8'h04);
    rd(4'h3, 2'h0, 8'hff, 8'h04);
    report_and_stop();
  end
endmodule
